/* File: crs_core.sv */
// crs_core: register file, pointers, extensions, flags, counter, stack and multiplier
`default_nettype none
module crs_core
	import crs_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_reset,
	input  wire crs_rf_req_t   i_rf,
	input  wire logic [15:0]   i_rf_wdata,
	output logic [7:0]         o_op_a,
	output logic [7:0]         o_op_b,
	output logic [15:0]        o_op_word,
	input  wire logic          i_alu_flags_we,
	input  wire logic [7:0]    i_alu_flags,
	output logic [7:0]         o_flags,
	input  wire logic          i_mul_start,
	input  wire crs_mul_mode_t i_mul_mode,
	input  wire logic [7:0]    i_mul_a,
	input  wire logic [7:0]    i_mul_b,
	input  wire crs_ptr_req_t  i_ptr,
	output logic [23:0]        o_data_addr,
	input  wire crs_pm_op_t    i_pm_op,
	output logic [23:0]        o_pm_addr,
	input  wire crs_io_req_t   i_io,
	output logic [7:0]         o_io_rdata,
	output logic               o_io_rvalid,
	input  wire crs_stk_op_t   i_stk_op,
	output logic [15:0]        o_stk_addr,
	output logic [21:0]        o_ret_push,
	input  wire logic [21:0]   i_ret_addr,
	input  wire logic          i_fetch_adv,
	input  wire logic          i_two_word,
	input  wire logic          i_jump,
	input  wire logic [21:0]   i_jump_target,
	output logic [21:0]        o_fetch_addr,
	output logic               o_fetch_en,
	input  wire logic          i_instr_done,
	output logic               o_irq_block
);
	logic [7:0]  rf [REG_COUNT];
	logic [21:0] pc;
	logic [7:0]  flags;
	logic [7:0]  ext_x;
	logic [7:0]  ext_y;
	logic [7:0]  table_pointer_extension;
	logic [2:0]  blk_cnt;
	logic [15:0] sp;
	logic        mul_valid;
	logic [15:0] mul_product;
	logic [4:0]  ptr_lo;
	logic [15:0] ptr_val;
	logic [7:0]  ptr_ext;
	logic [23:0] ptr_full;
	logic [15:0] next_ptr;
	logic        io_wr_spl;
	logic        io_wr_sph;
	logic        is_return;

	assign io_wr_spl = i_io.wr && (i_io.addr == IO_SPL);
	assign io_wr_sph = i_io.wr && (i_io.addr == IO_SPH);
	assign is_return = (i_stk_op == STK_RET) || (i_stk_op == STK_IRET);

	////////////////////////////////////////////////////////////////////////////
	// submodules

	crs_mul u_mul (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_start   (i_mul_start),
		.i_mode    (i_mul_mode),
		.i_a       (i_mul_a),
		.i_b       (i_mul_b),
		.o_valid   (mul_valid),
		.o_product (mul_product)
	);

	crs_stack u_stack (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.i_op    (i_stk_op),
		.i_wr_lo (io_wr_spl),
		.i_wr_hi (io_wr_sph),
		.i_wdata (i_io.wdata),
		.o_sp    (sp)
	);

	////////////////////////////////////////////////////////////////////////////
	// operand read ports, same-cycle for the alu

	assign o_op_a    = rf[i_rf.idx_a];
	assign o_op_b    = rf[i_rf.idx_b];
	assign o_op_word = {rf[crs_pair_base(i_rf.idx_a) | 5'h01], rf[crs_pair_base(i_rf.idx_a)]};

	////////////////////////////////////////////////////////////////////////////
	// pointer pairs and address forming

	always_comb begin
		unique case (i_ptr.sel)
			PSEL_X:  ptr_lo = PTR_X_LO;
			PSEL_Y:  ptr_lo = PTR_Y_LO;
			default: ptr_lo = PTR_Z_LO;
		endcase
	end

	always_comb begin
		unique case (i_ptr.sel)
			PSEL_X:  ptr_ext = ext_x;
			PSEL_Y:  ptr_ext = ext_y;
			default: ptr_ext = table_pointer_extension;
		endcase
	end

	assign ptr_val  = {rf[ptr_lo | 5'h01], rf[ptr_lo]};
	assign ptr_full = {ptr_ext, ptr_val};

	// the pointer update wraps inside 16 bits; the extension byte is left alone
	always_comb begin
		o_data_addr = ptr_full;
		next_ptr    = ptr_val;
		unique case (i_ptr.mode)
			PTR_DISP:    o_data_addr = ptr_full + {18'h00000, i_ptr.disp};
			PTR_POSTINC: next_ptr = ptr_val + 16'h0001;
			PTR_PREDEC: begin
				next_ptr    = ptr_val - 16'h0001;
				o_data_addr = {ptr_ext, next_ptr};
			end
			default:     next_ptr = ptr_val;
		endcase
	end

	// the data address never decodes into the working registers
	always_comb begin
		unique case (i_pm_op)
			PMO_EXT_LOAD,
			PMO_STORE: o_pm_addr = {table_pointer_extension, rf[PTR_Z_LO | 5'h01], rf[PTR_Z_LO]};
			PMO_LOAD:  o_pm_addr = {8'h00, rf[PTR_Z_LO | 5'h01], rf[PTR_Z_LO]};
			PMO_NONE:  o_pm_addr = 24'h000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// register file write-back, multiplier last so its product wins

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				rf[i] <= 8'h00;
			end
		end else begin
			if (i_ptr.en && (i_ptr.mode != PTR_DISP)) begin
				rf[ptr_lo]         <= next_ptr[7:0];
				rf[ptr_lo | 5'h01] <= next_ptr[15:8];
			end
			unique case (i_rf.wr_mode)
				WR_BYTE: rf[i_rf.dst] <= i_rf_wdata[7:0];
				WR_WORD: begin
					rf[crs_pair_base(i_rf.dst)]         <= i_rf_wdata[7:0];
					rf[crs_pair_base(i_rf.dst) | 5'h01] <= i_rf_wdata[15:8];
				end
				default: ;
			endcase
			if (mul_valid) begin
				rf[MUL_LO] <= mul_product[7:0];
				rf[MUL_HI] <= mul_product[15:8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// flags and extension registers; an io write beats an alu update

	// flags are never pushed or restored by interrupt entry or return
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			flags <= 8'h00;
		end else if (i_io.wr && (i_io.addr == IO_FLAGS)) begin
			flags <= i_io.wdata;
		end else if (i_alu_flags_we) begin
			flags <= i_alu_flags;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			ext_x                   <= 8'h00;
			ext_y                   <= 8'h00;
			table_pointer_extension <= 8'h00;
		end else if (i_io.wr) begin
			if (i_io.addr == IO_EXT_X) ext_x <= i_io.wdata & EXT_MASK;
			if (i_io.addr == IO_EXT_Y) ext_y <= i_io.wdata & EXT_MASK;
			if (i_io.addr == IO_EXT_Z) table_pointer_extension <= i_io.wdata & EXT_MASK;
		end
	end

	assign o_flags = flags;

	////////////////////////////////////////////////////////////////////////////
	// io read port, one cycle latency

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_io_rdata  <= 8'h00;
			o_io_rvalid <= 1'b0;
		end else begin
			o_io_rvalid <= i_io.rd;
			if (i_io.rd) begin
				unique case (i_io.addr)
					IO_FLAGS: o_io_rdata <= flags;
					IO_SPL:   o_io_rdata <= sp[7:0];
					IO_SPH:   o_io_rdata <= sp[15:8];
					IO_EXT_X: o_io_rdata <= ext_x;
					IO_EXT_Y: o_io_rdata <= ext_y;
					IO_EXT_Z: o_io_rdata <= table_pointer_extension;
					default:  o_io_rdata <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stack addresses and interrupt blocking after a low stack byte write

	assign o_stk_addr = ((i_stk_op == STK_POP) || is_return) ? sp + 16'h0001 : sp;
	assign o_ret_push = pc;

	// a new low byte write restarts the count even if a block is running
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			blk_cnt <= 3'h0;
		end else if (io_wr_spl) begin
			blk_cnt <= IRQ_BLOCK_INSTR;
		end else if (i_io.wr) begin
			blk_cnt <= 3'h0;
		end else if (i_instr_done && (blk_cnt != 3'h0)) begin
			blk_cnt <= blk_cnt - 3'h1;
		end
	end

	assign o_irq_block = (blk_cnt != 3'h0);

	////////////////////////////////////////////////////////////////////////////
	// instruction address counter and fetch

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pc <= PC_RESET;
		end else if (is_return) begin
			pc <= i_ret_addr;
		end else if (i_jump) begin
			pc <= i_jump_target;
		end else if (i_fetch_adv) begin
			pc <= pc + (i_two_word ? PC_STEP_TWO : PC_STEP_ONE);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_fetch_en <= 1'b0;
		end else begin
			o_fetch_en <= 1'b1;
		end
	end

	assign o_fetch_addr = pc;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	AST_MUL_TWO_CYCLES: assert property (i_mul_start |-> ##2
		({rf[MUL_HI], rf[MUL_LO]} == $past(crs_mul_calc(i_mul_mode, i_mul_a, i_mul_b), 2)))
		else $error("multiply product not in registers two cycles after issue");
	AST_PC_AFTER_RESET: assert property ($past(i_reset) |-> (o_fetch_addr == PC_RESET))
		else $error("counter not cleared by reset");
	AST_PC_TWO_WORD: assert property ((i_fetch_adv && i_two_word && !i_jump && !is_return)
		|=> (o_fetch_addr == $past(o_fetch_addr) + PC_STEP_TWO))
		else $error("double word fetch did not advance by two");
	AST_SP_AFTER_RESET: assert property ($past(i_reset) |-> (sp == SP_RESET))
		else $error("stack pointer not at sram top after reset");
	AST_PUSH_DEC: assert property ((i_stk_op == STK_PUSH && !io_wr_spl && !io_wr_sph)
		|=> (sp == $past(sp) - 16'h0001))
		else $error("push did not decrement the stack pointer");
	AST_CALL_MOVE: assert property ((i_stk_op == STK_CALL && !io_wr_spl && !io_wr_sph)
		|=> (sp == $past(sp) - RET_BYTES))
		else $error("call moved stack pointer by the wrong amount");
	AST_RET_MOVE: assert property ((is_return && !io_wr_spl && !io_wr_sph)
		|=> (sp == $past(sp) + RET_BYTES))
		else $error("return moved stack pointer by the wrong amount");
	AST_POP_INC: assert property ((i_stk_op == STK_POP && !io_wr_spl && !io_wr_sph)
		|=> (sp == $past(sp) + 16'h0001))
		else $error("pop did not increment the stack pointer");
	AST_RET_LOAD: assert property (is_return |=> (o_fetch_addr == $past(i_ret_addr)))
		else $error("return did not load the popped address");
	AST_BLOCK_START: assert property (io_wr_spl |=> o_irq_block)
		else $error("low stack byte write did not block interrupts");
	AST_BLOCK_END: assert property ((blk_cnt == 3'h1 && i_instr_done && !i_io.wr)
		|=> !o_irq_block)
		else $error("interrupt block lasted past four instructions");
	AST_BLOCK_IO: assert property ((o_irq_block && i_io.wr && !io_wr_spl) |=> !o_irq_block)
		else $error("io write did not end the interrupt block");
	AST_FLAGS_ALU: assert property ((i_alu_flags_we && !(i_io.wr && i_io.addr == IO_FLAGS))
		|=> (o_flags == $past(i_alu_flags)))
		else $error("flags not updated by alu operation");
	AST_EXT_BITS: assert property ((table_pointer_extension & ~EXT_MASK) == 8'h00)
		else $error("unimplemented extension bits set");
	AST_PLAIN_LOAD: assert property ((i_pm_op == PMO_LOAD) |-> (o_pm_addr[23:16] == 8'h00))
		else $error("plain program load used the extension byte");

	COV_MUL_FRAC:   cover property (i_mul_start && i_mul_mode == MUL_FSS);
	COV_CALL_RET:   cover property (i_stk_op == STK_CALL ##[1:20] is_return);
	COV_BLOCK_FULL: cover property (io_wr_spl ##1 o_irq_block [*4] ##1 !o_irq_block);
	COV_POSTINC:    cover property (i_ptr.en && i_ptr.mode == PTR_POSTINC);
endmodule : crs_core
`default_nettype wire

/* File: crs_pkg.sv */
// crs_pkg: constants, types and helpers of the cpu register file, stack and multiplier
//Contract
//- multiply two bytes to 16 bits: unsigned, signed, mixed, integer and fractional
//- a multiply lands its product in the register file two cycles after issue
//- reset clears the instruction address counter; it holds the next fetch address
//- fetch advances by one word, or by two for double-word instructions
//- reset loads the stack pointer with the top internal sram address
//- core runs on the undivided clock, fetching while executing, one per cycle
//- two operands read, computed and written back within one cycle
//- flags update after every alu operation and are readable and writable as io; an io write to flags in the same cycle wins over the alu update
//- flags are not saved or restored on interrupt entry and return
//- stack pointer is low and high byte registers in io space
//- stack grows down: push stores then decrements, pop increments then returns
//- calls and interrupts move the stack pointer by two or three bytes
//- subroutine and interrupt returns load the popped address into the counter
//- low stack byte write blocks interrupts four instructions or until io write
//- thirty-two byte registers with single-cycle access
//- four port schemes: byte or two bytes in, byte or word out, word to word
//- working registers have their own space; data accesses never reach them
//- indices 0x1a to 0x1f form three pointers, low byte at lower index
//- the third pointer also addresses program memory, signatures, fuses and locks
//- pointers support displacement, post-increment and pre-decrement
//- an extension byte forms the top of a 24-bit address above a pointer
//- extension registers implement only needed bits; others read as zero
//- extended loads and stores use the table extension; plain loads ignore it
`default_nettype none
package crs_pkg;
	localparam int          REG_COUNT       = 32;
	localparam logic [4:0]  PTR_X_LO        = 5'h1a;
	localparam logic [4:0]  PTR_Y_LO        = 5'h1c;
	localparam logic [4:0]  PTR_Z_LO        = 5'h1e;
	localparam logic [4:0]  MUL_LO          = 5'h00;
	localparam logic [4:0]  MUL_HI          = 5'h01;
	localparam int          PC_W            = 22;
	localparam logic [21:0] PC_RESET        = 22'h000000;
	localparam logic [15:0] SP_RESET        = 16'h3fff;
	localparam int          PMEM_KB         = 128;
	localparam int          PMEM_KB_SMALL   = 128;
	localparam logic [15:0] RET_BYTES       = (PMEM_KB > PMEM_KB_SMALL) ? 16'h0003 : 16'h0002;
	localparam logic [7:0]  EXT_MASK        = 8'h03;
	localparam logic [5:0]  IO_EXT_X        = 6'h39;
	localparam logic [5:0]  IO_EXT_Y        = 6'h3a;
	localparam logic [5:0]  IO_EXT_Z        = 6'h3b;
	localparam logic [5:0]  IO_SPL          = 6'h3d;
	localparam logic [5:0]  IO_SPH          = 6'h3e;
	localparam logic [5:0]  IO_FLAGS        = 6'h3f;
	localparam logic [2:0]  IRQ_BLOCK_INSTR = 3'h4;
	localparam logic [21:0] PC_STEP_ONE     = 22'h000001;
	localparam logic [21:0] PC_STEP_TWO     = 22'h000002;

	typedef enum logic [1:0] {WR_NONE, WR_BYTE, WR_WORD} crs_wr_mode_t;
	typedef enum logic [1:0] {PSEL_X, PSEL_Y, PSEL_Z} crs_ptr_sel_t;
	typedef enum logic [1:0] {PTR_DISP, PTR_POSTINC, PTR_PREDEC} crs_ptr_mode_t;
	typedef enum logic [1:0] {PMO_NONE, PMO_LOAD, PMO_EXT_LOAD, PMO_STORE} crs_pm_op_t;
	typedef enum logic [2:0] {STK_NONE, STK_PUSH, STK_POP, STK_CALL, STK_RET, STK_IRET} crs_stk_op_t;
	typedef enum logic [2:0] {MUL_UU, MUL_SS, MUL_SU, MUL_FUU, MUL_FSS, MUL_FSU} crs_mul_mode_t;

	typedef struct packed {
		logic [4:0]   idx_a;
		logic [4:0]   idx_b;
		crs_wr_mode_t wr_mode;
		logic [4:0]   dst;
	} crs_rf_req_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} crs_io_req_t;

	typedef struct packed {
		logic          en;
		crs_ptr_sel_t  sel;
		crs_ptr_mode_t mode;
		logic [5:0]    disp;
	} crs_ptr_req_t;

	function automatic logic [4:0] crs_pair_base(input logic [4:0] idx);
		return {idx[4:1], 1'b0};
	endfunction : crs_pair_base

	function automatic logic [15:0] crs_mul_calc(input crs_mul_mode_t mode,
			input logic [7:0] a, input logic [7:0] b);
		logic signed [8:0]  sa;
		logic signed [8:0]  sb;
		logic signed [17:0] p;
		logic [15:0]        r;
		sa = (mode inside {MUL_SS, MUL_SU, MUL_FSS, MUL_FSU}) ? {a[7], a} : {1'b0, a};
		sb = (mode inside {MUL_SS, MUL_FSS}) ? {b[7], b} : {1'b0, b};
		p = sa * sb;
		r = p[15:0];
		if (mode inside {MUL_FUU, MUL_FSS, MUL_FSU}) begin
			r = {r[14:0], 1'b0};
		end
		return r;
	endfunction : crs_mul_calc
endpackage : crs_pkg
`default_nettype wire

/* File: crs_mul.sv */
// crs_mul: registered byte multiplier, product valid one cycle after issue
`default_nettype none
module crs_mul
	import crs_pkg::*;
(
	input  wire logic          i_clk,
	input  wire logic          i_reset,
	input  wire logic          i_start,
	input  wire crs_mul_mode_t i_mode,
	input  wire logic [7:0]    i_a,
	input  wire logic [7:0]    i_b,
	output logic               o_valid,
	output logic [15:0]        o_product
);
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_valid <= 1'b0;
		end else begin
			o_valid <= i_start;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_product <= 16'h0000;
		end else if (i_start) begin
			o_product <= crs_mul_calc(i_mode, i_a, i_b);
		end
	end
endmodule : crs_mul
`default_nettype wire

/* File: crs_stack.sv */
// crs_stack: stack pointer with io byte writes and push, pop, call and return moves
`default_nettype none
module crs_stack
	import crs_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	input  wire crs_stk_op_t i_op,
	input  wire logic        i_wr_lo,
	input  wire logic        i_wr_hi,
	input  wire logic [7:0]  i_wdata,
	output logic [15:0]      o_sp
);
	// an io write to either byte overrides a stack move in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_sp <= SP_RESET;
		end else if (i_wr_lo) begin
			o_sp[7:0] <= i_wdata;
		end else if (i_wr_hi) begin
			o_sp[15:8] <= i_wdata;
		end else begin
			unique case (i_op)
				STK_PUSH: o_sp <= o_sp - 16'h0001;
				STK_POP:  o_sp <= o_sp + 16'h0001;
				STK_CALL: o_sp <= o_sp - RET_BYTES;
				STK_RET,
				STK_IRET: o_sp <= o_sp + RET_BYTES;
				STK_NONE: o_sp <= o_sp;
				default:  o_sp <= o_sp;
			endcase
		end
	end
endmodule : crs_stack
`default_nettype wire

/* File: crs_mem_model.sv */
// crs_mem_model: data memory stand-in holding pushed bytes and return addresses
`default_nettype none
module crs_mem_model
	import crs_pkg::*;
(
	input  wire logic        i_clk,
	input  wire crs_stk_op_t i_stk_op,
	input  wire logic [15:0] i_stk_addr,
	input  wire logic [21:0] i_ret_push,
	input  wire logic [7:0]  i_push_data,
	output logic [21:0]      o_ret_addr,
	output logic [7:0]       o_pop_data
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] mem [0:65535];

	// unwritten cells hold a pattern, never a stale value
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'ha5;
		end
	end

	always @(posedge i_clk) begin
		if (i_stk_op == STK_PUSH) begin
			mem[i_stk_addr] <= i_push_data;
		end
		if (i_stk_op == STK_CALL) begin
			mem[i_stk_addr]         <= i_ret_push[7:0];
			mem[i_stk_addr - 16'h1] <= i_ret_push[15:8];
		end
	end

	assign o_pop_data = mem[i_stk_addr];
	assign o_ret_addr = {6'h00, mem[i_stk_addr], mem[i_stk_addr + 16'h1]};
endmodule : crs_mem_model
`default_nettype wire

/* File: test_cpu_regfile_stack_multiplier.sv */
// test_cpu_regfile_stack_multiplier: self-checking bench of crs_core with a stack memory model
`default_nettype none
module test_cpu_regfile_stack_multiplier
	import crs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic          i_clk = 1'b0, i_reset = 1'b1;
	crs_rf_req_t   i_rf = '0;
	logic [15:0]   i_rf_wdata = '0;
	logic          i_alu_flags_we = 1'b0, i_mul_start = 1'b0;
	logic [7:0]    i_alu_flags = '0, i_mul_a = '0, i_mul_b = '0, push_data = '0, pop_data;
	crs_mul_mode_t i_mul_mode = MUL_UU;
	crs_ptr_req_t  i_ptr = '0;
	crs_pm_op_t    i_pm_op = PMO_NONE;
	crs_io_req_t   i_io = '0;
	crs_stk_op_t   i_stk_op = STK_NONE;
	logic          i_fetch_adv = 1'b0, i_two_word = 1'b0, i_jump = 1'b0, i_instr_done = 1'b0;
	logic [21:0]   i_jump_target = '0, i_ret_addr, o_ret_push, o_fetch_addr;
	logic [7:0]    o_op_a, o_op_b, o_flags, o_io_rdata;
	logic [15:0]   o_op_word, o_stk_addr;
	logic [23:0]   o_data_addr, o_pm_addr;
	logic          o_io_rvalid, o_fetch_en, o_irq_block;
	int            errors = 0, cmp_count = 0, cycles = 0, seed = 32'h8df99079;

	crs_core dut (
		.i_clk(i_clk), .i_reset(i_reset), .i_rf(i_rf), .i_rf_wdata(i_rf_wdata),
		.o_op_a(o_op_a), .o_op_b(o_op_b), .o_op_word(o_op_word),
		.i_alu_flags_we(i_alu_flags_we), .i_alu_flags(i_alu_flags), .o_flags(o_flags),
		.i_mul_start(i_mul_start), .i_mul_mode(i_mul_mode), .i_mul_a(i_mul_a),
		.i_mul_b(i_mul_b), .i_ptr(i_ptr), .o_data_addr(o_data_addr), .i_pm_op(i_pm_op),
		.o_pm_addr(o_pm_addr), .i_io(i_io), .o_io_rdata(o_io_rdata),
		.o_io_rvalid(o_io_rvalid), .i_stk_op(i_stk_op), .o_stk_addr(o_stk_addr),
		.o_ret_push(o_ret_push), .i_ret_addr(i_ret_addr), .i_fetch_adv(i_fetch_adv),
		.i_two_word(i_two_word), .i_jump(i_jump), .i_jump_target(i_jump_target),
		.o_fetch_addr(o_fetch_addr), .o_fetch_en(o_fetch_en),
		.i_instr_done(i_instr_done), .o_irq_block(o_irq_block)
	);

	crs_mem_model mem (.i_clk(i_clk), .i_stk_op(i_stk_op), .i_stk_addr(o_stk_addr),
		.i_ret_push(o_ret_push), .i_push_data(push_data), .o_ret_addr(i_ret_addr),
		.o_pop_data(pop_data));

	always #5 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one edge, then every request except i_pm_op back to idle
	task automatic nxt;
		@(posedge i_clk);
		i_rf.wr_mode <= WR_NONE;
		i_alu_flags_we <= 1'b0;
		i_mul_start <= 1'b0;
		i_ptr.en <= 1'b0;
		i_io <= '0;
		i_stk_op <= STK_NONE;
		i_fetch_adv <= 1'b0;
		i_two_word <= 1'b0;
		i_jump <= 1'b0;
		i_instr_done <= 1'b0;
	endtask : nxt

	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		nxt;
		i_io <= '{1'b1, 1'b0, a, d};
	endtask : io_wr

	task automatic io_rd(input string w, input logic [5:0] a, input logic [7:0] e);
		nxt;
		i_io <= '{1'b0, 1'b1, a, 8'h00};
		nxt;
		#1;
		chk(w, {16'h0, e}, {16'h0, o_io_rdata});
		chk("rvalid", 24'h1, {23'h0, o_io_rvalid});
	endtask : io_rd

	function automatic logic [15:0] mul_exp(input int m, input logic [7:0] a, input logic [7:0] b);
		int x;
		int y;
		x = a;
		y = b;
		if (m == 1 || m == 2 || m == 4 || m == 5) x = $signed(a);
		if (m == 1 || m == 4) y = $signed(b);
		return (m >= 3) ? 16'((x * y) << 1) : 16'(x * y);
	endfunction : mul_exp

	task automatic results;
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int k;
		logic [15:0] x, y;
		logic [7:0]  rf_exp [32];
		logic [15:0] mexp [14];
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		#1;
		chk("fetch_en_rst", 24'h0, {23'h0, o_fetch_en});
		nxt;
		i_fetch_adv <= 1'b1;
		#1;
		chk("pc_rst", 24'h0, {2'h0, o_fetch_addr});
		chk("sp_rst", {8'h0, SP_RESET}, {8'h0, o_stk_addr});
		chk("fetch_en", 24'h1, {23'h0, o_fetch_en});
		chk("flags_rst", 24'h0, {16'h0, o_flags});
		nxt;
		i_fetch_adv <= 1'b1;
		i_two_word <= 1'b1;
		#1;
		chk("pc_one", 24'h1, {2'h0, o_fetch_addr});
		nxt;
		#1;
		chk("pc_two", 24'h3, {2'h0, o_fetch_addr});
		for (k = 0; k < 32; k++) begin
			nxt;
			x = 16'($random(seed));
			rf_exp[k] = x[7:0];
			i_rf <= '{5'(k), 5'd0, WR_BYTE, 5'(k)};
			i_rf_wdata <= x;
		end
		for (k = 0; k < 32; k++) begin
			nxt;
			i_rf <= '{5'(k), 5'(31 - k), WR_NONE, 5'd0};
			#1;
			chk("rf_a", {16'h0, rf_exp[k]}, {16'h0, o_op_a});
			chk("rf_b", {16'h0, rf_exp[31 - k]}, {16'h0, o_op_b});
		end
		for (k = 0; k < 3; k++) begin
			x = 16'($random(seed));
			nxt;
			i_rf <= '{PTR_X_LO + 5'(2 * k), 5'd0, WR_WORD, PTR_X_LO + 5'(2 * k)};
			i_rf_wdata <= x;
			nxt;
			i_ptr <= '{1'b1, crs_ptr_sel_t'(k), PTR_DISP, 6'h3f};
			#1;
			chk("word", {8'h0, x}, {8'h0, o_op_word});
			chk("lo", {16'h0, x[7:0]}, {16'h0, o_op_a});
			chk("disp", {8'h0, x} + 24'h3f, o_data_addr);
			nxt;
			i_ptr <= '{1'b1, crs_ptr_sel_t'(k), PTR_POSTINC, 6'h0};
			#1;
			chk("postinc", {8'h0, x}, o_data_addr);
			nxt;
			i_ptr <= '{1'b1, crs_ptr_sel_t'(k), PTR_PREDEC, 6'h0};
			#1;
			chk("inc", {8'h0, x + 16'h1}, {8'h0, o_op_word});
			chk("predec", {8'h0, x}, o_data_addr);
			nxt;
			#1;
			chk("dec", {8'h0, x}, {8'h0, o_op_word});
		end
		io_wr(IO_EXT_Z, 8'hff);
		io_rd("ext_mask", IO_EXT_Z, EXT_MASK);
		for (k = 1; k < 4; k++) begin
			nxt;
			i_pm_op <= crs_pm_op_t'(k);
			#1;
			chk("pm_addr", {(k == 1) ? 8'h00 : EXT_MASK, x}, o_pm_addr);
		end
		y = 16'($random(seed));
		nxt;
		i_alu_flags_we <= 1'b1;
		i_alu_flags <= y[7:0];
		nxt;
		#1;
		chk("alu_flags", {16'h0, y[7:0]}, {16'h0, o_flags});
		io_rd("flags_rd", IO_FLAGS, y[7:0]);
		io_wr(IO_FLAGS, 8'ha3);
		i_alu_flags_we <= 1'b1;
		nxt;
		#1;
		chk("flags_wr", 24'ha3, {16'h0, o_flags});
		io_wr(IO_SPH, 8'h21);
		io_wr(IO_SPL, 8'h34);
		for (k = 0; k < 4; k++) begin
			nxt;
			i_instr_done <= 1'b1;
			#1;
			chk("irq_blk", 24'h1, {23'h0, o_irq_block});
		end
		nxt;
		#1;
		chk("irq_free", 24'h0, {23'h0, o_irq_block});
		io_wr(IO_SPL, 8'h34);
		io_wr(6'h20, 8'h77);
		#1;
		chk("irq_blk2", 24'h1, {23'h0, o_irq_block});
		nxt;
		#1;
		chk("irq_iowr", 24'h0, {23'h0, o_irq_block});
		chk("sp_io", 24'h2134, {8'h0, o_stk_addr});
		io_rd("unmapped", 6'h20, 8'h00);
		io_rd("spl_rd", IO_SPL, 8'h34);
		io_rd("sph_rd", IO_SPH, 8'h21);
		nxt;
		i_stk_op <= STK_PUSH;
		push_data <= 8'hc3;
		nxt;
		i_stk_op <= STK_PUSH;
		push_data <= 8'h3c;
		#1;
		chk("push", 24'h2133, {8'h0, o_stk_addr});
		nxt;
		i_stk_op <= STK_POP;
		#1;
		chk("pop_last", 24'h3c, {16'h0, pop_data});
		nxt;
		i_stk_op <= STK_POP;
		#1;
		chk("pop_first", 24'hc3, {16'h0, pop_data});
		nxt;
		i_jump <= 1'b1;
		i_jump_target <= {6'h0, x};
		#1;
		chk("pop_sp", 24'h2134, {8'h0, o_stk_addr});
		nxt;
		i_stk_op <= STK_CALL;
		#1;
		chk("ret_push", {8'h0, x}, {2'h0, o_ret_push});
		nxt;
		i_jump <= 1'b1;
		i_jump_target <= {6'h0, y};
		#1;
		chk("call_sp", 24'h2132, {8'h0, o_stk_addr});
		nxt;
		i_stk_op <= STK_CALL;
		nxt;
		i_jump <= 1'b1;
		i_jump_target <= 22'h0;
		nxt;
		i_stk_op <= STK_IRET;
		nxt;
		i_stk_op <= STK_RET;
		#1;
		chk("iret_pc", {8'h0, y}, {2'h0, o_fetch_addr});
		nxt;
		#1;
		chk("ret_pc", {8'h0, x}, {2'h0, o_fetch_addr});
		chk("ret_sp", 24'h2134, {8'h0, o_stk_addr});
		chk("flags_kept", 24'ha3, {16'h0, o_flags});
		i_rf <= '0;
		for (k = 0; k < 14; k++) begin
			nxt;
			if (k < 12) begin
				x = 16'($random(seed));
				if (k == 2) x = 16'hffff;
				if (k == 4) x = 16'h8080;
				i_mul_start <= 1'b1;
				i_mul_mode <= crs_mul_mode_t'(k % 6);
				i_mul_a <= x[15:8];
				i_mul_b <= x[7:0];
				mexp[k] = mul_exp(k % 6, x[15:8], x[7:0]);
			end
			#1;
			if (k >= 2) chk("mul", {8'h0, mexp[k - 2]}, {8'h0, o_op_word});
		end
		results();
	end
endmodule : test_cpu_regfile_stack_multiplier
`default_nettype wire
